// *** core/fsk_router_consts.svh ***
// register map, field positions, reset values and shift ranges
`ifndef FSK_ROUTER_CONSTS_SVH
`define FSK_ROUTER_CONSTS_SVH
// register byte offsets
`define ADDR_CTRL 4'h0
`define ADDR_CMD 4'h4
`define ADDR_BAUD 4'h8
`define ADDR_STAT 4'hc
// control register fields
`define CTRL_COMB 0
`define CTRL_TWO 1
`define CTRL_INV 2
`define CTRL_DUAL 3
`define CTRL_WIDE 4
`define CTRL_MASTER 5
`define CTRL_AGC_LO 6
`define CTRL_AGC_HI 7
// command register fields, each a one-shot press
`define CMD_FSK 0
`define CMD_RUNTOG 1
`define CMD_NONFSK 2
`define CMD_SWAPRX 3
// reset values
`define CTRL_RST 8'h00
`define BAUD_RST 16'h0100
// symmetrical shift ranges in tenths of a hertz
`define NARROW_LO 16'h01a9
`define NARROW_HI 16'h03e8
`define MEDIUM_LO 16'h03e8
`define MEDIUM_HI 16'h0fa0
`define WIDE_LO 16'h0fa0
`define WIDE_HI 16'h2710
// line level driven out of reset, and on hv_out off a wideband module
`define MARK_IDLE 1'b1
`endif

// *** core/fsk_router_pkg.sv ***
// types shared by the printer router
package fsk_router_pkg;
    typedef enum logic [1:0] {
        OP_OFF = 2'b01,
        OP_FSK = 2'b10
    } op_t;
    typedef enum logic [2:0] {
        narrow_shift_mode = 3'b001,
        medium_shift_mode = 3'b010,
        wide_shift_mode = 3'b100
    } shift_t;
endpackage : fsk_router_pkg

// *** core/bit_fifo.sv ***
// flip-flop fifo with valid/ready on both sides
module bit_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic rdy_r;
    logic val_r;
    logic push;
    logic pop;

    assign push = in_valid && rdy_r;
    assign pop = out_ready && val_r;
    assign in_ready = rdy_r;
    assign out_valid = val_r;
    assign out_data = mem_r[rp_r];

    // occupancy after this cycle's push and pop
    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + CW'(1);
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    // pointers and flags kept as flops so both ready and valid are clean
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b0;
            val_r <= 1'b0;
        end else if (ce) begin
            if (push) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
            end
            cnt_r <= cnt_nxt;
            rdy_r <= (cnt_nxt != CW'(DEPTH));
            val_r <= (cnt_nxt != '0);
        end
    end

    // storage, written only on an accepted push
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule : bit_fifo

// *** core/fsk_printer_output_router.sv ***
// routes demodulated fsk data of two channels to the printer outputs
// What this block does
// - single receiver independent: demod to main
// - combined: stronger channel drives main output
// - dual, two printers: rx1 main, rx2 secondary
// - dual, one printer: main follows controlled receiver
// - receiver swap alone never moves main source
// - dual combined: stronger to main, secondary idle
// - normal polarity mark low, inverted mark high
// - high voltage output carries main channel only on a wideband module
// - wideband press rotates three shift modes
// - shift ranges narrow, medium, wide as listed
// - entering fsk resumes last shift mode
// - stepping modes keeps polarity and agc
// - toggle switches output between hold and run
// - toggle acts on monitored or combined channel
// - non-fsk mode or mute forces hold
// - combined master configures slave receiver itself
//
// Added by the designer: the placing of the registers and the plain strobed port.
`include "fsk_router_consts.svh"
module fsk_printer_output_router (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // demodulator pins and same-clock demod side
    input wire logic demod_rx1,
    input wire logic demod_rx2,
    input wire logic bit_stb,
    output logic bit_rdy,
    input wire logic [7:0] strength1,
    input wire logic [7:0] strength2,
    input wire logic mute,
    // printer outputs
    output logic main_out,
    output logic main_en,
    output logic sec_out,
    output logic sec_en,
    output logic hv_out,
    // demodulator shift setting and slave setup
    output fsk_router_pkg::shift_t shift_mode,
    output logic [15:0] shift_min,
    output logic [15:0] shift_max,
    output logic slave_cfg_stb,
    output logic [7:0] slave_cfg
);
    import fsk_router_pkg::*;

    logic [7:0] ctrl_r;
    logic [15:0] baud_r;
    logic [15:0] baud_cnt_r;
    logic [15:0] rdata_r;
    logic rx1_s1_r;
    logic rx1_s2_r;
    logic rx2_s1_r;
    logic rx2_s2_r;
    op_t op_r;
    shift_t shift_r;
    logic [1:0] run_r;
    logic ctrl_rx_r;
    logic main_src_r;
    logic main_out_r;
    logic main_en_r;
    logic sec_out_r;
    logic sec_en_r;
    logic hv_out_r;
    logic [15:0] shift_min_r;
    logic [15:0] shift_max_r;
    logic slave_stb_r;
    logic [7:0] slave_cfg_r;
    logic comb;
    logic two;
    logic mark_high_polarity;
    logic dual;
    logic wide;
    logic single_pr;
    logic strong2;
    logic [1:0] route_bits;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [1:0] fifo_out_data;
    logic tick;
    logic pop;
    logic main_run;
    logic sec_run;
    logic run_idx;
    logic cmd_wr;
    logic press_fsk;
    logic press_tog;
    logic force_hold;

    // next mode in the wideband rotation
    function automatic shift_t shift_next(input shift_t s);
        unique case (s)
            narrow_shift_mode: shift_next = medium_shift_mode;
            medium_shift_mode: shift_next = wide_shift_mode;
            wide_shift_mode: shift_next = narrow_shift_mode;
            default: shift_next = narrow_shift_mode;
        endcase
    endfunction : shift_next

    // line level of a data bit; demod bit high means mark
    function automatic logic line_level(input logic b, input logic iv);
        line_level = iv ? b : ~b;
    endfunction : line_level

    assign comb = ctrl_r[`CTRL_COMB];
    assign two = ctrl_r[`CTRL_TWO];
    assign mark_high_polarity = ctrl_r[`CTRL_INV];
    assign dual = ctrl_r[`CTRL_DUAL];
    assign wide = ctrl_r[`CTRL_WIDE];
    assign single_pr = dual && !comb && !two;
    assign cmd_wr = wr && (addr == `ADDR_CMD);
    assign press_fsk = cmd_wr && wdata[`CMD_FSK];
    assign press_tog = cmd_wr && wdata[`CMD_RUNTOG];
    assign force_hold = (op_r != OP_FSK) || mute;
    // diversity combiner picks the larger signal
    assign strong2 = (strength2 > strength1);

    // demod pins come from another domain: two flops before use
    always_ff @(posedge clk) begin
        if (rst) begin
            rx1_s1_r <= 1'b0;
            rx1_s2_r <= 1'b0;
            rx2_s1_r <= 1'b0;
            rx2_s2_r <= 1'b0;
        end else if (ce) begin
            rx1_s1_r <= demod_rx1;
            rx1_s2_r <= rx1_s1_r;
            rx2_s1_r <= demod_rx2;
            rx2_s2_r <= rx2_s1_r;
        end
    end

    // source selection, bit 0 main and bit 1 secondary
    always_comb begin
        // a single receiver feeds main from its demodulator
        route_bits = {1'b0, rx1_s2_r};
        if (comb) begin
            // stronger of the two channels feeds main
            // secondary carries nothing in combined routing
            route_bits = {1'b0, strong2 ? rx2_s2_r : rx1_s2_r};
        end else if (dual && two) begin
            // rx1 to main, rx2 to secondary
            route_bits = {rx2_s2_r, rx1_s2_r};
        end else if (dual) begin
            // single printer follows the latched source
            route_bits = {1'b0, main_src_r ? rx2_s2_r : rx1_s2_r};
        end
    end

    // configuration and baud registers
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= `CTRL_RST;
            baud_r <= `BAUD_RST;
        end else if (ce && wr) begin
            if (addr == `ADDR_CTRL) begin
                ctrl_r <= wdata[7:0];
            end
            if (addr == `ADDR_BAUD) begin
                baud_r <= wdata;
            end
        end
    end

    // master in combined pair pushes its setup to the slave
    always_ff @(posedge clk) begin
        if (rst) begin
            slave_stb_r <= 1'b0;
            slave_cfg_r <= `CTRL_RST;
        end else if (ce) begin
            slave_stb_r <= 1'b0;
            if (wr && addr == `ADDR_CTRL && wdata[`CTRL_MASTER]
                    && wdata[`CTRL_COMB] && !wdata[`CTRL_DUAL]) begin
                slave_stb_r <= 1'b1;
                slave_cfg_r <= wdata[7:0] & ~(8'h01 << `CTRL_MASTER);
            end
        end
    end

    // operating mode: fsk or some other detection mode
    always_ff @(posedge clk) begin
        if (rst) begin
            op_r <= OP_OFF;
        end else if (ce && cmd_wr) begin
            if (wdata[`CMD_NONFSK]) begin
                op_r <= OP_OFF;
            end else if (wdata[`CMD_FSK]) begin
                op_r <= OP_FSK;
            end
        end
    end

    // shift mode is kept across non-fsk spells
    // first press only re-enters the stored mode
    // later presses on a wideband module rotate it
    // only the mode moves; polarity and agc bits stay
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_r <= narrow_shift_mode;
        end else if (ce && press_fsk && !wdata[`CMD_NONFSK]) begin
            if (op_r == OP_FSK && wide) begin
                shift_r <= shift_next(shift_r);
            end
        end
    end

    // shift range handed to the demodulator per mode
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_min_r <= `NARROW_LO;
            shift_max_r <= `NARROW_HI;
        end else if (ce) begin
            unique case (shift_r)
                narrow_shift_mode: begin
                    shift_min_r <= `NARROW_LO;
                    shift_max_r <= `NARROW_HI;
                end
                medium_shift_mode: begin
                    shift_min_r <= `MEDIUM_LO;
                    shift_max_r <= `MEDIUM_HI;
                end
                wide_shift_mode: begin
                    shift_min_r <= `WIDE_LO;
                    shift_max_r <= `WIDE_HI;
                end
                default: begin
                    shift_min_r <= `NARROW_LO;
                    shift_max_r <= `NARROW_HI;
                end
            endcase
        end
    end

    // receiver under front panel control and monitoring
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_rx_r <= 1'b0;
        end else if (ce && cmd_wr && wdata[`CMD_SWAPRX] && dual) begin
            ctrl_rx_r <= ~ctrl_rx_r;
        end
    end

    // toggle hits the monitored channel, or slot 0 when combined or not dual
    assign run_idx = (comb || !dual) ? 1'b0 : ctrl_rx_r;

    // hold/run gate per channel
    always_ff @(posedge clk) begin
        if (rst) begin
            run_r <= 2'b00;
        end else if (ce) begin
            if (force_hold) begin
                // non-fsk or mute overrides any toggle
                run_r <= 2'b00;
            end else if (press_tog) begin
                run_r[run_idx] <= ~run_r[run_idx];
            end
        end
    end

    // single-printer source only changes when run is set in fsk
    always_ff @(posedge clk) begin
        if (rst) begin
            main_src_r <= 1'b0;
        end else if (ce && single_pr && !force_hold && press_tog
                && !run_r[ctrl_rx_r]) begin
            main_src_r <= ctrl_rx_r;
        end
    end

    // gates seen by each printer output
    assign main_run = single_pr ? run_r[main_src_r] : run_r[0];
    assign sec_run = dual && two && !comb && run_r[1];

    // bit pacing divider; a slow printer stalls the fifo, not the data
    always_ff @(posedge clk) begin
        if (rst) begin
            baud_cnt_r <= '0;
        end else if (ce) begin
            baud_cnt_r <= tick ? '0 : baud_cnt_r + 16'h0001;
        end
    end
    assign tick = (baud_cnt_r >= baud_r);
    assign pop = tick && fifo_out_valid;

    bit_fifo #(
        .WIDTH(2),
        .DEPTH(16)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .in_valid(bit_stb),
        .in_ready(fifo_in_ready),
        .in_data(route_bits),
        .out_valid(fifo_out_valid),
        .out_ready(tick),
        .out_data(fifo_out_data)
    );

    // back-pressure is the fifo's own ready flop; a delayed copy would
    // promise room for one push too many once the fifo fills
    assign bit_rdy = fifo_in_ready;

    // printer line drivers; a held output idles at mark level
    always_ff @(posedge clk) begin
        if (rst) begin
            main_out_r <= `MARK_IDLE;
            sec_out_r <= `MARK_IDLE;
            hv_out_r <= `MARK_IDLE;
            main_en_r <= 1'b0;
            sec_en_r <= 1'b0;
        end else if (ce) begin
            main_en_r <= main_run;
            sec_en_r <= sec_run;
            if (!main_run) begin
                main_out_r <= line_level(1'b1, mark_high_polarity);
                hv_out_r <= line_level(1'b1, mark_high_polarity);
            end else if (pop) begin
                // normal drives mark low, inverted mark high
                main_out_r <= line_level(fifo_out_data[0], mark_high_polarity);
                // high voltage driver mirrors the main channel on a wideband module only
                hv_out_r <= wide ? line_level(fifo_out_data[0], mark_high_polarity)
                                 : `MARK_IDLE;
            end
            if (!sec_run) begin
                sec_out_r <= line_level(1'b1, mark_high_polarity);
            end else if (pop) begin
                sec_out_r <= line_level(fifo_out_data[1], mark_high_polarity);
            end
        end
    end

    // read data valid in the cycle after the strobe; unmapped reads 0
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (ce) begin
            rdata_r <= '0;
            if (rd) begin
                unique case (addr)
                    `ADDR_CTRL: rdata_r <= {8'h00, ctrl_r};
                    `ADDR_BAUD: rdata_r <= baud_r;
                    `ADDR_STAT: rdata_r <= {6'h00, !fifo_in_ready,
                        fifo_out_valid, shift_r, main_src_r, ctrl_rx_r,
                        run_r, op_r == OP_FSK};
                    default: rdata_r <= '0;
                endcase
            end
        end
    end

    assign rdata = rdata_r;
    assign main_out = main_out_r;
    assign main_en = main_en_r;
    assign sec_out = sec_out_r;
    assign sec_en = sec_en_r;
    assign hv_out = hv_out_r;
    assign shift_mode = shift_r;
    assign shift_min = shift_min_r;
    assign shift_max = shift_max_r;
    assign slave_cfg_stb = slave_stb_r;
    assign slave_cfg = slave_cfg_r;

    // no output runs straight out of reset
    a_hold_after_reset: assert property (@(posedge clk)
        $fell(rst) |-> run_r == 2'b00 && !main_en_r)
        else $error("gate not held after reset");

    // forced hold closes the gate next cycle
    a_force_hold_gate: assert property (@(posedge clk) disable iff (rst)
        ce && force_hold |=> run_r == 2'b00)
        else $error("hold not forced");

    sequence s_pop_run;
        ce && pop && main_run;
    endsequence
    // line level follows bit and polarity
    a_polarity_mark: assert property (@(posedge clk) disable iff (rst)
        s_pop_run |=> main_out_r ==
            ($past(mark_high_polarity) ? $past(fifo_out_data[0]) : !$past(fifo_out_data[0])))
        else $error("wrong line polarity");

    // high voltage line tracks main on a wideband module
    a_hv_main_only: assert property (@(posedge clk) disable iff (rst)
        s_pop_run ##0 wide |=> hv_out_r == main_out_r)
        else $error("hv line not main channel");

    sequence s_wide_press;
        ce && press_fsk && !wdata[`CMD_NONFSK] && op_r == OP_FSK && wide;
    endsequence
    // each press inside fsk on a wideband module advances the rotation
    a_mode_rotate: assert property (@(posedge clk) disable iff (rst)
        s_wide_press |=> shift_r == shift_next($past(shift_r)))
        else $error("shift mode did not rotate");

    // entering fsk keeps the remembered mode
    a_mode_resume: assert property (@(posedge clk) disable iff (rst)
        ce && press_fsk && op_r == OP_OFF |=> $stable(shift_r))
        else $error("mode lost on fsk entry");

    // a mode step leaves polarity and agc alone
    a_step_keeps_pol: assert property (@(posedge clk) disable iff (rst)
        s_wide_press |=> $stable(ctrl_r))
        else $error("setup changed by mode step");

    // swapping control does not move the printer source
    a_src_on_swap: assert property (@(posedge clk) disable iff (rst)
        ce && cmd_wr && wdata[`CMD_SWAPRX] && !wdata[`CMD_RUNTOG]
            |=> $stable(main_src_r))
        else $error("source moved on receiver swap");

    // secondary stays disabled in dual combined routing
    a_comb_sec_idle: assert property (@(posedge clk) disable iff (rst)
        ce && comb ##1 ce && $stable(ctrl_r) |-> !sec_en_r)
        else $error("secondary used while combined");
endmodule : fsk_printer_output_router

// *** test/printer_model.sv ***
// behavioural printer that latches the line while its input is enabled
module printer_model (
    // clocking
    input wire logic clk,
    // printer line
    input wire logic line,
    input wire logic en,
    // last level taken in
    output logic seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // single loop printer
    // only one current-loop printer hangs on the main line of the module
    initial seen = 1'b0;
    // a held output is ignored, so stale idle levels never count as data
    always @(posedge clk) begin
        if (en === 1'b1) begin
            seen <= line;
        end
    end
endmodule : printer_model

// *** test/tb_top.sv ***
// self-checking bench for the fsk printer router
`include "fsk_router_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fsk_router_pkg::*;
    logic clk, rst, wr, rd, rx1, rx2, stb, rdy, mute;
    logic [3:0] addr;
    logic [15:0] wdata, rdata, v, smin, smax;
    logic [7:0] s1, s2, scfg, got_cfg;
    logic mo, men, so, sen, hv, sstb, seen;
    shift_t sm;
    shift_t exp_m [5];
    int errors = 0, checks = 0, cyc = 0, n_stb = 0, n;
    fsk_printer_output_router i_fsk_printer_output_router (
        .clk(clk), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .demod_rx1(rx1),
        .demod_rx2(rx2), .bit_stb(stb), .bit_rdy(rdy), .strength1(s1),
        .strength2(s2), .mute(mute), .main_out(mo), .main_en(men),
        .sec_out(so), .sec_en(sen), .hv_out(hv), .shift_mode(sm),
        .shift_min(smin), .shift_max(smax), .slave_cfg_stb(sstb),
        .slave_cfg(scfg));
    printer_model i_printer_model (.clk(clk), .line(mo), .en(men),
        .seen(seen));
    // clock; reset is driven by the main sequence
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // watch slave setup pulses; they last one cycle so count every edge
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (sstb === 1'b1) begin
            n_stb <= n_stb + 1;
            got_cfg <= scfg;
        end
        if (cyc == 30000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [15:0] e,
            input logic [15:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // read data stands only in the cycle after the strobe; taken settled
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg
    task automatic rd_chk(input string nm, input logic [3:0] a,
            input logic [15:0] e);
        rd_reg(a, v);
        chk(nm, e, v);
    endtask : rd_chk
    // four cycles cover the pin sync, ten cover a drain tick at baud 3
    task automatic send(input logic b1, input logic b2);
        @(posedge clk);
        rx1 <= b1;
        rx2 <= b2;
        repeat (4) @(posedge clk);
        stb <= 1'b1;
        @(posedge clk);
        stb <= 1'b0;
        repeat (10) @(posedge clk);
    endtask : send
    task automatic cmd(input logic [15:0] d);
        wr_reg(`ADDR_CMD, d);
        repeat (2) @(posedge clk);
        #1;
    endtask : cmd
    function automatic logic [15:0] lo_of(input shift_t m);
        return (m == narrow_shift_mode) ? `NARROW_LO :
            (m == medium_shift_mode) ? `MEDIUM_LO : `WIDE_LO;
    endfunction : lo_of
    function automatic logic [15:0] hi_of(input shift_t m);
        return (m == narrow_shift_mode) ? `NARROW_HI :
            (m == medium_shift_mode) ? `MEDIUM_HI : `WIDE_HI;
    endfunction : hi_of
    // main sequence
    initial begin
        rst = 1'b1;
        {wr, rd, rx1, rx2, stb, mute} = 6'h00;
        addr = 4'h0;
        wdata = 16'h0000;
        s1 = 8'h0a;
        s2 = 8'h14;
        exp_m = '{narrow_shift_mode, medium_shift_mode, wide_shift_mode,
            narrow_shift_mode, medium_shift_mode};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("main_en", 16'h0000, men);
        chk("shift_mode", narrow_shift_mode, sm);
        rd_chk("ctrl", `ADDR_CTRL, 16'h0000);
        rd_chk("baud", `ADDR_BAUD, `BAUD_RST);
        rd_chk("unmapped", 4'h2, 16'h0000);
        wr_reg(`ADDR_STAT, 16'hffff);
        rd_chk("stat", `ADDR_STAT, 16'h0020);
        wr_reg(`ADDR_BAUD, 16'h0003);
        // toggle outside fsk operation must leave the gate held
        cmd(16'h0002);
        chk("main_en", 16'h0000, men);
        cmd(16'h0001);
        cmd(16'h0002);
        chk("main_en", 16'h0001, men);
        rd_chk("stat", `ADDR_STAT, 16'h0023);
        send(1'b0, 1'b0);
        chk("main_out", 16'h0001, seen);
        chk("hv_out", 16'h0001, hv);
        send(1'b1, 1'b0);
        chk("main_out", 16'h0000, seen);
        chk("hv_out idle", 16'h0001, hv);
        wr_reg(`ADDR_CTRL, 16'h0004);
        send(1'b1, 1'b0);
        chk("main_out inv", 16'h0001, seen);
        // combined routing: rx2 wins only when strictly stronger
        wr_reg(`ADDR_CTRL, 16'h0001);
        send(1'b0, 1'b1);
        chk("main_out comb", 16'h0000, seen);
        s2 <= 8'h0a;
        send(1'b0, 1'b1);
        chk("main_out tie", 16'h0001, seen);
        s2 <= 8'h14;
        mute <= 1'b1;
        repeat (3) @(posedge clk);
        chk("main_en mute", 16'h0000, men);
        mute <= 1'b0;
        cmd(16'h0002);
        chk("main_en comb", 16'h0001, men);
        cmd(16'h0004);
        chk("main_en nonfsk", 16'h0000, men);
        // dual, two printers: each receiver owns its own output
        wr_reg(`ADDR_CTRL, 16'h000a);
        cmd(16'h0001);
        cmd(16'h0002);
        cmd(16'h0008);
        cmd(16'h0002);
        chk("sec_en", 16'h0001, sen);
        send(1'b1, 1'b0);
        chk("main_out dual", 16'h0000, seen);
        chk("sec_out dual", 16'h0001, so);
        // dual, one printer: swap alone must not move the source
        cmd(16'h0004);
        wr_reg(`ADDR_CTRL, 16'h0008);
        cmd(16'h0001);
        cmd(16'h0002);
        send(1'b0, 1'b1);
        chk("main_out rx2", 16'h0000, seen);
        chk("sec_en one", 16'h0000, sen);
        cmd(16'h0008);
        send(1'b0, 1'b1);
        chk("main_out swap", 16'h0000, seen);
        cmd(16'h0002);
        send(1'b0, 1'b1);
        chk("main_out rx1", 16'h0001, seen);
        wr_reg(`ADDR_CTRL, 16'h0009);
        send(1'b0, 1'b1);
        chk("main_out dcomb", 16'h0000, seen);
        chk("sec_en dcomb", 16'h0000, sen);
        wr_reg(`ADDR_CTRL, 16'h0021);
        wr_reg(`ADDR_CTRL, 16'h0001);
        repeat (2) @(posedge clk);
        chk("slave_stb", 16'h0001, n_stb[15:0]);
        chk("slave_cfg", 16'h0001, got_cfg);
        // wideband rotation, then re-entry resumes the last mode
        cmd(16'h0004);
        wr_reg(`ADDR_CTRL, 16'h00d4);
        for (n = 0; n < 5; n++) begin
            cmd(16'h0001);
            chk("shift_mode", exp_m[n], sm);
            chk("shift_min", lo_of(exp_m[n]), smin);
            chk("shift_max", hi_of(exp_m[n]), smax);
        end
        cmd(16'h0004);
        cmd(16'h0001);
        chk("shift resume", medium_shift_mode, sm);
        rd_chk("ctrl keep", `ADDR_CTRL, 16'h00d4);
        // fifo: fill until refused, then drain with a fast divider
        cmd(16'h0002);
        // wideband module: the high voltage line follows main data
        send(1'b0, 1'b0);
        chk("main_out wide", 16'h0000, seen);
        chk("hv_out wide", 16'h0000, hv);
        wr_reg(`ADDR_BAUD, 16'hffff);
        repeat (8) @(posedge clk);
        n = 0;
        stb <= 1'b1;
        repeat (20) begin
            @(posedge clk);
            if (rdy === 1'b1) begin
                n++;
            end
        end
        stb <= 1'b0;
        chk("accepted", 16'h0010, n[15:0]);
        rd_reg(`ADDR_STAT, v);
        chk("full", 16'h0001, v[9]);
        wr_reg(`ADDR_BAUD, 16'h0000);
        repeat (40) @(posedge clk);
        rd_reg(`ADDR_STAT, v);
        chk("not empty", 16'h0000, v[8]);
        chk("bit_rdy", 16'h0001, rdy);
        wrap_up();
    end
endmodule : tb_top
